// *** shared/usart_core_regs.svh ***
// Constants for the serial frame core: field positions, reset values and timing counts
`ifndef USART_CORE_REGS_SVH
`define USART_CORE_REGS_SVH

`define USART_BAUD_PERIOD_SETTING_W        12
`define USART_BAUD_PERIOD_SETTING_MAX      4095
`define USART_FRAME_W       13
`define USART_BITIDX_W      4
`define USART_CNT_W         15
`define USART_CHAR_BASE     4'h5
`define USART_CHAR_SEL_MAX  3'h4
`define USART_SPI_BITS      4'h8
`define USART_ASYNC_HALF_SH 3
`define USART_FIFO_DEPTH    16
`define USART_RX_WORD_W     12
`define USART_RXW_OVF       11
`define USART_RXW_FRAME_ERROR_FLAG      10
`define USART_RXW_PARITY_ERROR_FLAG      9
`define USART_TXBUF_RST     9'h000
`define USART_LINE_IDLE     1'b1
`define USART_FRAME_RST     13'h1fff

`endif

// *** shared/usart_core_pkg.sv ***
// Types shared by the serial frame core and its testbench
package usart_core_pkg;
    typedef enum logic [1:0] {MODE_ASYNC, MODE_SYNC, MODE_SPI} mode_e;
    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_e;
    typedef struct packed {
        logic       overflow;
        logic       frameErr;
        logic       parityErr;
        logic [8:0] data;
    } rx_word_s;
endpackage : usart_core_pkg

// *** shared/fifo_if.sv ***
// Push and pop handshake between the frame core and its receive FIFO
`timescale 1ns/10ps
interface fifo_if #(parameter int WIDTH = 12);
    logic             pushValid;
    logic             pushReady;
    logic [WIDTH-1:0] pushData;
    logic             popValid;
    logic             popReady;
    logic [WIDTH-1:0] popData;
    logic             flush;
    modport buffer (input pushValid, pushData, popReady, flush,
                    output pushReady, popValid, popData);
    modport user   (output pushValid, pushData, popReady, flush,
                    input pushReady, popValid, popData);
endinterface : fifo_if

// *** logic/sync_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/10ps
module sync_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,   // Core clock
    input wire logic rst,       // Async reset, high
    fifo_if.buffer   port       // Push/pop handshake
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    logic   doPush;
    logic   doPop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("sync_fifo depth must be a power of two of at least 2");
    end

    // Handshake outputs
    assign port.pushReady = (s_r.count != (AW+1)'(DEPTH));
    assign port.popValid  = (s_r.count != '0);
    assign port.popData   = s_r.mem[s_r.rdPtr];
    assign doPush = port.pushValid & port.pushReady;
    assign doPop  = port.popReady & port.popValid;

    // Next state
    always_comb begin
        s_nxt = s_r;
        if (port.flush) begin
            s_nxt.wrPtr = '0;
            s_nxt.rdPtr = '0;
            s_nxt.count = '0;
        end else begin
            if (doPush) begin
                s_nxt.mem[s_r.wrPtr] = port.pushData;
                s_nxt.wrPtr = s_r.wrPtr + 1'b1;
            end
            if (doPop) begin
                s_nxt.rdPtr = s_r.rdPtr + 1'b1;
            end
            s_nxt.count = s_r.count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    property p_fifo_bound;
        @(posedge sys_clk) disable iff (rst) s_r.count <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_bound : assert property (p_fifo_bound) else $error("FIFO count past depth");

    property p_fifo_flush;
        @(posedge sys_clk) disable iff (rst) port.flush |=> !port.popValid;
    endproperty
    a_fifo_flush : assert property (p_fifo_flush) else $error("FIFO not empty after flush");
endmodule : sync_fifo

// *** logic/usart_frame_tx_rx_core.sv ***
// Serial frame core: async/sync/SPI master transmitter and buffered receiver
`timescale 1ns/10ps
`include "usart_core_regs.svh"
module usart_frame_tx_rx_core #(
    parameter int FIFO_DEPTH = `USART_FIFO_DEPTH
) (
    input  wire logic                        sys_clk,               // Core clock, 125 MHz
    input  wire logic                        rst,                   // Async reset, high
    input  wire usart_core_pkg::mode_e       mode,                  // Async, sync or SPI master
    input  wire logic [2:0]                  charSizeSel,           // 0..4 for 5..9 bits
    input  wire usart_core_pkg::parity_e     parityMode,            // None, even, odd
    input  wire logic                        twoStopBits,           // Second stop bit
    input  wire logic                        spiLsbFirst,           // SPI bit order
    input  wire logic                        clock_phase_select,    // SPI clock phase
    input  wire logic                        pin_invert_enable,     // Clock pin inversion
    input  wire logic [11:0]                 baud_period_setting,   // Divider period
    input  wire logic                        txEnable,              // Transmitter enable
    input  wire logic                        rxEnable,              // Receiver enable
    input  wire logic [7:0]                  txData,                // Low byte to send
    input  wire logic                        tx_ninth_bit,          // Ninth bit to send
    input  wire logic                        txWrite,               // Buffer write pulse
    input  wire logic                        txCompleteClear,       // Clear pulse
    output logic                             tx_buffer_empty_flag,  // Buffer accepts data
    output logic                             tx_complete_flag,      // Sticky done flag
    output logic                             serial_out_pin_n,      // Serial data out
    output logic                             serialOutOe,           // Pin driven by core
    output logic                             transfer_clock_pin,    // Shift clock out
    output logic                             transferClockOe,       // Clock pin driven
    input  wire logic                        serialInPin,           // Serial data in
    input  wire logic                        rxRead,                // Data read pulse
    output logic [7:0]                       rxData,                // Head frame low byte
    output logic                             rx_ninth_bit,          // Head frame ninth bit
    output logic                             rx_complete_flag,      // Frame buffered
    output logic                             frame_error_flag,      // Head frame error
    output logic                             rx_overflow_flag,      // Head frame overflow
    output logic                             parity_error_flag      // Head frame parity
);
    import usart_core_pkg::*;

    typedef enum logic {TX_IDLE, TX_SHIFT} tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_e;

    typedef struct packed {
        tx_e                        txState;
        logic [`USART_CNT_W-1:0]    txCnt;
        logic                       txHalf;
        logic [`USART_BITIDX_W-1:0] txIdx;
        logic [`USART_BITIDX_W-1:0] txLen;
        logic [`USART_FRAME_W-1:0]  txFrame;
        logic [8:0]                 txBuf;
        logic                       txBufFull;
        logic                       txDone;
        logic                       txDriving;
        rx_e                        rxState;
        logic [`USART_CNT_W-1:0]    rxCnt;
        logic                       rxHalf;
        logic [`USART_BITIDX_W-1:0] rxIdx;
        logic [`USART_FRAME_W-1:0]  rxBits;
        logic                       rxPrev;
        logic                       ovfPending;
        logic                       pushValid;
        rx_word_s                   pushWord;
    } state_s;

    state_s                     s_r;
    state_s                     s_nxt;
    logic [`USART_CNT_W-1:0]    halfLimit;
    logic                       effPhase;
    logic                       txTick;
    logic                       frameEnd;
    logic [`USART_FRAME_W-1:0]  loadFrame;
    logic [`USART_BITIDX_W-1:0] loadLen;
    logic [`USART_BITIDX_W-1:0] rxLast;
    rx_word_s                   headWord;

    fifo_if #(.WIDTH(`USART_RX_WORD_W)) rxq ();

    if (FIFO_DEPTH < 2) begin : g_chk
        $error("receive FIFO depth below 2");
    end

    sync_fifo #(.WIDTH(`USART_RX_WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .sys_clk (sys_clk),
        .rst     (rst),
        .port    (rxq.buffer)
    );

    // Frame assembly for the shift register
    function automatic void buildTx(input logic [8:0] d, output logic [12:0] f,
                                    output logic [3:0] len);
        logic [3:0] n;
        logic [8:0] dm;
        n  = 4'(charSizeSel) + `USART_CHAR_BASE;
        dm = '0;
        f  = `USART_FRAME_RST;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) dm[i] = d[i];
        end
        if (mode == MODE_SPI) begin
            for (int i = 0; i < 8; i++) begin
                f[i] = spiLsbFirst ? d[i] : d[7-i];
            end
            len = `USART_SPI_BITS;
        end else begin
            f[0] = 1'b0;
            for (int i = 0; i < 9; i++) begin
                if (4'(i) < n) f[i+1] = dm[i];
            end
            if (parityMode != PAR_NONE) begin
                f[4'(n + 4'd1)] = (parityMode == PAR_EVEN) ? ^dm : ~^dm;
            end
            len = 4'(4'd2 + n + 4'(parityMode != PAR_NONE) + 4'(twoStopBits));
        end
    endfunction : buildTx

    // Frame decode with error flags
    function automatic rx_word_s decodeRx(input logic [12:0] b);
        logic [3:0] n;
        logic       p;
        logic       stop;
        decodeRx = '0;
        n = 4'(charSizeSel) + `USART_CHAR_BASE;
        if (mode == MODE_SPI) begin
            for (int i = 0; i < 8; i++) begin
                decodeRx.data[i] = spiLsbFirst ? b[i] : b[7-i];
            end
        end else begin
            for (int i = 0; i < 9; i++) begin
                if (4'(i) < n) decodeRx.data[i] = b[i+1];
            end
            p    = b[4'(n + 4'd1)];
            stop = (parityMode == PAR_NONE) ? b[4'(n + 4'd1)] : b[4'(n + 4'd2)];
            decodeRx.frameErr = ~stop;
            if (parityMode == PAR_EVEN) decodeRx.parityErr = p ^ (^decodeRx.data);
            if (parityMode == PAR_ODD) decodeRx.parityErr = p ^ (~^decodeRx.data);
        end
    endfunction : decodeRx

    // Half-bit period: sync/SPI n+1 cycles, async 8(n+1)
    assign halfLimit = (mode == MODE_ASYNC) ?
        `USART_CNT_W'((({3'h0, baud_period_setting} + 15'h1) << `USART_ASYNC_HALF_SH) - 15'h1) :
        {3'h0, baud_period_setting};
    assign effPhase = (mode == MODE_SPI) ? clock_phase_select : 1'b1;
    assign txTick   = (s_r.txState == TX_SHIFT) && (s_r.txCnt == halfLimit);
    assign frameEnd = txTick && s_r.txHalf && (s_r.txIdx == 4'(s_r.txLen - 4'd1));
    assign rxLast   = 4'(`USART_CHAR_BASE + 4'(charSizeSel) + 4'(parityMode != PAR_NONE) + 4'd1);
    always_comb buildTx(s_r.txBuf, loadFrame, loadLen);

    // Pins and flags
    assign serial_out_pin_n     = (s_r.txState == TX_SHIFT) ? s_r.txFrame[0] : `USART_LINE_IDLE;
    assign serialOutOe          = s_r.txDriving;
    assign transfer_clock_pin   = pin_invert_enable ^
        ((s_r.txState == TX_SHIFT) && (s_r.txHalf != effPhase));
    assign transferClockOe      = (mode != MODE_ASYNC);
    assign tx_buffer_empty_flag = ~s_r.txBufFull;
    assign tx_complete_flag     = s_r.txDone;
    assign headWord             = rxq.popData;
    assign rxData               = headWord.data[7:0];
    assign rx_ninth_bit         = headWord.data[8];
    assign rx_complete_flag     = rxq.popValid;
    assign frame_error_flag     = headWord.frameErr;
    assign parity_error_flag    = headWord.parityErr;
    assign rx_overflow_flag     = headWord.overflow;
    assign rxq.pushValid        = s_r.pushValid;
    assign rxq.pushData         = s_r.pushWord;
    assign rxq.popReady         = rxRead;
    assign rxq.flush            = ~rxEnable;

    // Transmitter and receiver next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.pushValid = 1'b0;
        s_nxt.rxPrev    = serialInPin;
        if (txWrite && txEnable && !s_r.txBufFull) begin
            s_nxt.txBuf     = {tx_ninth_bit, txData};
            s_nxt.txBufFull = 1'b1;
        end
        if (txCompleteClear) s_nxt.txDone = 1'b0;
        if (s_r.txState == TX_IDLE) begin
            if (s_r.txBufFull) begin
                s_nxt.txState   = TX_SHIFT;
                s_nxt.txFrame   = loadFrame;
                s_nxt.txLen     = loadLen;
                s_nxt.txIdx     = '0;
                s_nxt.txHalf    = 1'b0;
                s_nxt.txCnt     = '0;
                s_nxt.txBufFull = 1'b0;
                s_nxt.txDriving = 1'b1;
            end else if (!txEnable) begin
                s_nxt.txDriving = 1'b0;
            end else begin
                s_nxt.txDriving = 1'b1;
            end
        end else if (txTick) begin
            s_nxt.txCnt  = '0;
            s_nxt.txHalf = ~s_r.txHalf;
            if (!s_r.txHalf && mode != MODE_ASYNC && rxEnable) begin
                s_nxt.rxBits[s_r.txIdx] = serialInPin;
            end
            if (frameEnd) begin
                if (mode != MODE_ASYNC && rxEnable) begin
                    s_nxt.pushValid = 1'b1;
                    s_nxt.pushWord  = decodeRx(s_r.rxBits);
                end
                if (s_r.txBufFull) begin
                    s_nxt.txFrame   = loadFrame;
                    s_nxt.txLen     = loadLen;
                    s_nxt.txIdx     = '0;
                    s_nxt.txBufFull = 1'b0;
                end else begin
                    s_nxt.txState = TX_IDLE;
                    s_nxt.txDone  = 1'b1;
                end
            end else if (s_r.txHalf) begin
                s_nxt.txFrame = {1'b1, s_r.txFrame[12:1]};
                s_nxt.txIdx   = s_r.txIdx + 4'd1;
            end
        end else begin
            s_nxt.txCnt = s_r.txCnt + 15'h1;
        end
        // Async receiver, sampling mid-bit from a half-bit start check
        if (mode == MODE_ASYNC) begin
            case (s_r.rxState)
                RX_IDLE: begin
                    s_nxt.rxCnt = '0;
                    if (s_r.rxPrev && !serialInPin) s_nxt.rxState = RX_START;
                end
                RX_START: begin
                    s_nxt.rxCnt = s_r.rxCnt + 15'h1;
                    if (s_r.rxCnt == halfLimit) begin
                        s_nxt.rxCnt     = '0;
                        s_nxt.rxHalf    = 1'b0;
                        s_nxt.rxIdx     = 4'd1;
                        s_nxt.rxBits[0] = 1'b0;
                        s_nxt.rxState   = serialInPin ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: begin
                    s_nxt.rxCnt = s_r.rxCnt + 15'h1;
                    if (s_r.rxCnt == halfLimit) begin
                        s_nxt.rxCnt  = '0;
                        s_nxt.rxHalf = ~s_r.rxHalf;
                        if (s_r.rxHalf) begin
                            s_nxt.rxBits[s_r.rxIdx] = serialInPin;
                            s_nxt.rxIdx = s_r.rxIdx + 4'd1;
                            if (s_r.rxIdx == rxLast) begin
                                s_nxt.rxState   = RX_IDLE;
                                s_nxt.pushValid = 1'b1;
                                s_nxt.pushWord  = decodeRx(s_nxt.rxBits);
                            end
                        end
                    end
                end
                default: s_nxt.rxState = RX_IDLE;
            endcase
        end else begin
            s_nxt.rxState = RX_IDLE;
        end
        // Overflow: frame dropped, next stored frame carries the mark
        if (s_r.pushValid && !rxq.pushReady) begin
            s_nxt.ovfPending = 1'b1;
        end else if (s_r.pushValid) begin
            s_nxt.ovfPending = 1'b0;
        end
        if (s_nxt.pushValid) s_nxt.pushWord.overflow = s_nxt.ovfPending;
        if (!rxEnable) begin
            s_nxt.rxState    = RX_IDLE;
            s_nxt.pushValid  = 1'b0;
            s_nxt.ovfPending = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r         <= '0;
            s_r.txFrame <= `USART_FRAME_RST;
            s_r.txBuf   <= `USART_TXBUF_RST;
            s_r.rxPrev  <= `USART_LINE_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    property p_idle_high;
        @(posedge sys_clk) disable iff (rst) s_r.txState == TX_IDLE |-> serial_out_pin_n;
    endproperty
    a_idle_high : assert property (p_idle_high) else $error("idle line not high");

    property p_start_low;
        @(posedge sys_clk) disable iff (rst)
            $rose(s_r.txState == TX_SHIFT) && mode != MODE_SPI |-> !serial_out_pin_n;
    endproperty
    a_start_low : assert property (p_start_low) else $error("frame did not open low");

    property p_complete;
        @(posedge sys_clk) disable iff (rst) frameEnd && !s_r.txBufFull |=> tx_complete_flag;
    endproperty
    a_complete : assert property (p_complete) else $error("complete flag missing");

    property p_buf_taken;
        @(posedge sys_clk) disable iff (rst)
            txWrite && txEnable && tx_buffer_empty_flag |=> !tx_buffer_empty_flag;
    endproperty
    a_buf_taken : assert property (p_buf_taken) else $error("write not buffered");

    property p_release;
        @(posedge sys_clk) disable iff (rst)
            !txEnable && s_r.txState == TX_IDLE && !s_r.txBufFull ##1 !txWrite |-> !serialOutOe;
    endproperty
    a_release : assert property (p_release) else $error("pin kept after disable");

    property p_rx_flush;
        @(posedge sys_clk) disable iff (rst) !rxEnable |=> !rx_complete_flag;
    endproperty
    a_rx_flush : assert property (p_rx_flush) else $error("buffer kept after disable");

    property p_clock_idle;
        @(posedge sys_clk) disable iff (rst)
            s_r.txState == TX_IDLE |-> transfer_clock_pin == pin_invert_enable;
    endproperty
    a_clock_idle : assert property (p_clock_idle) else $error("clock idle level wrong");

    property p_spi_len;
        @(posedge sys_clk) disable iff (rst)
            mode == MODE_SPI && $rose(s_r.txState == TX_SHIFT) |-> s_r.txLen == 4'd8;
    endproperty
    a_spi_len : assert property (p_spi_len) else $error("SPI frame not eight bits");

    property p_upper_zero;
        @(posedge sys_clk) disable iff (rst)
            s_r.pushValid && mode != MODE_SPI |->
                (s_r.pushWord.data >> (4'(charSizeSel) + 4'd5)) == 9'h000;
    endproperty
    a_upper_zero : assert property (p_upper_zero) else $error("unused bits not zero");

    c_back_to_back : cover property (@(posedge sys_clk) disable iff (rst)
        frameEnd && s_r.txBufFull);
    c_rx_push : cover property (@(posedge sys_clk) disable iff (rst)
        s_r.pushValid && rxq.pushReady);
    c_overflow : cover property (@(posedge sys_clk) disable iff (rst)
        s_r.pushValid && !rxq.pushReady);
    c_spi_frame : cover property (@(posedge sys_clk) disable iff (rst)
        frameEnd && mode == MODE_SPI);
endmodule : usart_frame_tx_rx_core

// *** tb/serial_node_model.sv ***
// Remote serial node wired in loopback: echoes each frame it hears
`timescale 1ns/10ps
module serial_node_model (
    input  wire logic lineIn,  // Device serial out
    input  wire logic lineOe,  // Device drives line
    output logic      lineOut  // Device serial in
);
    // Whole frames echoed, released line pulled high
    assign lineOut = lineOe ? lineIn : 1'b1;
endmodule : serial_node_model

// *** tb/usart_frame_tx_rx_core_tb_top.sv ***
// Bench: async, sync and SPI loopback frames checked against a queue model
`timescale 1ns/10ps
module usart_frame_tx_rx_core_tb_top;
    import usart_core_pkg::*;
    logic sys_clk = 0, rst = 1, txEnable = 0, rxEnable = 0, twoStopBits = 0;
    logic txWrite = 0, txCompleteClear = 0, rxRead = 0, tx_ninth_bit = 0;
    logic [2:0] charSizeSel = 0;
    parity_e parityMode = PAR_NONE;
    mode_e mode = MODE_ASYNC;
    logic spiLsbFirst = 0, clock_phase_select = 0, pin_invert_enable = 0, clkPrev = 0;
    logic [11:0] baud = 12'h000;
    logic transfer_clock_pin, transferClockOe;
    logic [7:0] txData = 0, rxData;
    logic tx_buffer_empty_flag, tx_complete_flag, serial_out_pin_n, serialOutOe;
    logic rx_ninth_bit, rx_complete_flag, frame_error_flag, rx_overflow_flag;
    logic parity_error_flag, serialInPin;
    int bad_count = 0, check_count = 0, cycleCount = 0, seed = 39250, k, n;
    int clkEdges = 0, e0, bits;
    logic [11:0] q[$];
    logic ovfPend = 0;
    initial forever #4 sys_clk = ~sys_clk;
    serial_node_model peer (.lineIn(serial_out_pin_n), .lineOe(serialOutOe),
                            .lineOut(serialInPin));
    usart_frame_tx_rx_core uut (.sys_clk, .rst, .mode, .charSizeSel,
        .parityMode, .twoStopBits, .spiLsbFirst, .clock_phase_select,
        .pin_invert_enable, .baud_period_setting(baud), .txEnable,
        .rxEnable, .txData, .tx_ninth_bit, .txWrite, .txCompleteClear,
        .tx_buffer_empty_flag, .tx_complete_flag, .serial_out_pin_n, .serialOutOe,
        .transfer_clock_pin, .transferClockOe, .serialInPin, .rxRead, .rxData,
        .rx_ninth_bit, .rx_complete_flag, .frame_error_flag, .rx_overflow_flag,
        .parity_error_flag);
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic waitHigh(ref logic flag);
        for (n = 0; flag !== 1'b1 && n < 600; n++) @(negedge sys_clk);
    endtask : waitHigh
    // Write one frame and log what the receiver should buffer
    task automatic send();
        logic [8:0] d;
        d = 9'($random(seed));
        waitHigh(tx_buffer_empty_flag);
        txData = d[7:0];
        tx_ninth_bit = d[8];
        txWrite = 1;
        @(negedge sys_clk) txWrite = 0;
        if (mode == MODE_SPI) d[8] = 1'b0;
        else d = d & 9'((1 << (5 + charSizeSel)) - 1);
        if (q.size() == 16) ovfPend = 1;
        else begin
            q.push_back({ovfPend, 2'b00, d});
            ovfPend = 0;
        end
    endtask : send
    task automatic readAll();
        while (q.size() > 0) begin
            waitHigh(rx_complete_flag);
            check({rx_overflow_flag, frame_error_flag, parity_error_flag, rx_ninth_bit,
                   rxData}, q.pop_front());
            rxRead = 1;
            @(negedge sys_clk);
        end
        rxRead = 0;
    endtask : readAll
    // Wait for the line to drain, then clear the sticky complete flag
    task automatic drain();
        waitHigh(tx_complete_flag);
        check({10'h000, tx_complete_flag, serial_out_pin_n}, 12'h003);
        txCompleteClear = 1;
        @(negedge sys_clk) txCompleteClear = 0;
    endtask : drain
    // Shift clock pin changes, counted from the value held before each edge
    always @(posedge sys_clk) begin
        if (transfer_clock_pin !== clkPrev) clkEdges++;
        clkPrev = transfer_clock_pin;
    end
    always @(posedge sys_clk) if (++cycleCount > 40000) begin
        bad_count++;
        summarize();
    end
    initial begin
        repeat (12) @(negedge sys_clk);
        rst = 0;
        txEnable = 1; // format settled before the enables
        rxEnable = 1;
        // Every size, parity and stop count, pairs back to back, then overfill
        for (k = 0; k < 13; k++) begin
            charSizeSel = 3'(k % 5); // format changed only with the line drained
            parityMode = parity_e'(k % 3);
            twoStopBits = k[0];
            send();
            send();
            drain();
            if (k == 3) readAll();
        end
        readAll();
        send();
        drain();
        readAll();
        // Sync in its one fixed phase with inversion off, SPI master in every phase and inversion, looped back
        baud = 12'h001;
        for (k = 0; k < 6; k++) begin
            mode = (k < 2) ? MODE_SYNC : MODE_SPI;
            clock_phase_select = k[0]; // changed only while idle
            pin_invert_enable = k[1];
            spiLsbFirst = k[2];
            @(negedge sys_clk) e0 = clkEdges;
            bits = (mode == MODE_SPI) ? 8 :
                   7 + charSizeSel + (parityMode != PAR_NONE) + twoStopBits;
            send();
            send();
            drain();
            check(12'(clkEdges - e0), 12'(4 * bits));
            check({10'h000, transferClockOe, transfer_clock_pin},
                  {10'h000, 1'b1, pin_invert_enable});
            readAll();
        end
        // Receiver disable drops buffered frames
        mode = MODE_ASYNC;
        baud = 12'h000;
        send();
        drain();
        check({11'h000, rx_complete_flag}, 12'h001);
        rxEnable = 0;
        @(negedge sys_clk) check({11'h000, rx_complete_flag}, 12'h000);
        // Transmitter disable releases the pin once drained
        txEnable = 0;
        @(negedge sys_clk) check({11'h000, serialOutOe}, 12'h000);
        summarize();
    end
endmodule : usart_frame_tx_rx_core_tb_top
